// ---- core/spmc_consts.svh ----
// What this block does
// - Line 0 output and high puts the first port in RS-232 mode.
// - Line 2 output and high puts the second port in RS-232 mode.
// - Line 0 output and low puts the first port in RS-422/485 mode.
// - Line 2 output and low puts the second port in RS-422/485 mode.
// - Line 1 high selects half duplex on the first port, low full.
// - Line 3 high selects half duplex on the second port, low full.
// - Both ports come up in RS-232 mode after reset.
// - Each port has 16550-style registers, up to 115.2 kbaud.
// - Mode and duplex of one port never touch the other port.
// - In RS-422/485 the driver is enabled by hardware, receiver always on.
// - Half-duplex RS-485 joins the pairs; RS-422 keeps them apart.
// - RS-232 mode offers the full 9-wire data and modem set.
`ifndef SPMC_CONSTS_SVH
`define SPMC_CONSTS_SVH
// Timing
`define SPMC_CLK_HZ 20000000
`define SPMC_MAX_BAUD 115200
`define SPMC_MIN_DIV ((`SPMC_CLK_HZ + `SPMC_MAX_BAUD - 1) / `SPMC_MAX_BAUD)
// Global register addresses
`define SPMC_A_GPIO_OUT 8'h00
`define SPMC_A_GPIO_DIR 8'h01
`define SPMC_A_MODE_STAT 8'h02
// Port windows: high nibble selects port, low nibble the register
`define SPMC_PSEL0 4'h1
`define SPMC_R_DATA 4'h0
`define SPMC_R_LSR 4'h1
`define SPMC_R_DIVL 4'h2
`define SPMC_R_DIVH 4'h3
`define SPMC_R_MCR 4'h4
`define SPMC_R_MSR 4'h5
// Reset values
`define SPMC_GPIO_RST 4'h0
`define SPMC_MCR_RST 2'h0
// Line layout: per port a mode line then a duplex line
`define SPMC_LINES_PER_PORT 2
// Modem control bits
`define SPMC_MCR_DTR 0
`define SPMC_MCR_RTS 1
`endif

// ---- core/spmc_pkg.sv ----
package spmc_pkg;
  typedef enum logic {MODE_RS232, MODE_RS485} port_mode_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef struct packed {
    logic rxd;
    logic cts;
    logic dsr;
    logic dcd;
    logic ri;
  } m232_in_t;
  typedef struct packed {
    logic txd;
    logic rts;
    logic dtr;
    logic drv_en;
  } m232_out_t;
  typedef struct packed {
    logic tx;
    logic de;
    logic rx_en;
    logic pair_join;
  } r485_out_t;
endpackage

// ---- core/uart_engine.sv ----
`timescale 1ns/10ps
module uart_engine
  import spmc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Setup and transmit side
  input  wire logic [15:0] div,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_load,
  output logic             thr_empty,
  output logic             tx_busy,
  output logic             txd,
  // Receive side
  input  wire logic        rxd,
  input  wire logic        rbr_clr,
  input  wire logic        oe_clr,
  output logic [7:0]       rx_byte,
  output logic             rx_ready,
  output logic             rx_over
);
  tx_state_t tx_st_q;
  rx_state_t rx_st_q;
  logic [15:0] cnt_q, rcnt_q;
  logic [2:0]  bit_q, rbit_q;
  logic [7:0]  thr_q, sh_q, rsh_q, rbr_q;
  logic        thr_full_q, txd_q, dr_q, oe_q;
  logic        tick, rtick, rhalf, take, done;

  // Bit timers; receiver checks the start bit at half period
  assign tick  = cnt_q == div - 16'h0001;
  assign rtick = rcnt_q == div - 16'h0001;
  assign rhalf = rcnt_q == {1'b0, div[15:1]};
  // Holding register moves to the shifter with no idle gap
  assign take  = thr_full_q && (tx_st_q == TX_IDLE || (tx_st_q == TX_STOP && tick));
  assign done  = rx_st_q == RX_STOP && rtick && rxd;

  // Holding register; a write in the same cycle as a take refills it and keeps it full
  always_ff @(posedge mclk) begin
    if (srst) begin
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
    end else begin
      if (tx_load) thr_q <= tx_byte;
      thr_full_q <= tx_load | (thr_full_q & ~take);
    end
  end

  // Transmit sequencer, fixed 8N1 framing
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_st_q <= TX_IDLE;
      cnt_q   <= 16'h0000;
      bit_q   <= 3'h0;
      sh_q    <= 8'h00;
      txd_q   <= 1'b1;
    end else begin
      cnt_q <= (tick || tx_st_q == TX_IDLE) ? 16'h0000 : cnt_q + 16'h0001;
      if (take) begin
        sh_q    <= thr_q;
        txd_q   <= 1'b0;
        tx_st_q <= TX_START;
      end else begin
        case (tx_st_q)
          TX_START: if (tick) begin
            tx_st_q <= TX_DATA;
            txd_q   <= sh_q[0];
            bit_q   <= 3'h0;
          end
          TX_DATA: if (tick) begin
            if (bit_q == 3'h7) begin
              tx_st_q <= TX_STOP;
              txd_q   <= 1'b1;
            end else begin
              bit_q <= bit_q + 3'h1;
              sh_q  <= {1'b0, sh_q[7:1]};
              txd_q <= sh_q[1];
            end
          end
          TX_STOP: if (tick) tx_st_q <= TX_IDLE;
          default: ;
        endcase
      end
    end
  end

  // Receive sequencer; a bad stop bit drops the character
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_st_q <= RX_IDLE;
      rcnt_q  <= 16'h0000;
      rbit_q  <= 3'h0;
      rsh_q   <= 8'h00;
    end else begin
      rcnt_q <= (rtick || rx_st_q == RX_IDLE || (rx_st_q == RX_START && rhalf))
                ? 16'h0000 : rcnt_q + 16'h0001;
      case (rx_st_q)
        RX_IDLE: if (!rxd) rx_st_q <= RX_START;
        RX_START: if (rhalf) begin
          rx_st_q <= rxd ? RX_IDLE : RX_DATA;
          rbit_q  <= 3'h0;
        end
        RX_DATA: if (rtick) begin
          rsh_q  <= {rxd, rsh_q[7:1]};
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == 3'h7) rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rtick) rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Ready and overrun flags: a new character wins over the clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      rbr_q <= 8'h00;
      dr_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      if (done) rbr_q <= rsh_q;
      dr_q <= done | (dr_q & ~rbr_clr);
      oe_q <= (done & dr_q & ~rbr_clr) | (oe_q & ~oe_clr);
    end
  end

  assign thr_empty = ~thr_full_q;
  assign tx_busy   = tx_st_q != TX_IDLE;
  assign txd       = txd_q;
  assign rx_byte   = rbr_q;
  assign rx_ready  = dr_q;
  assign rx_over   = oe_q;
endmodule

// ---- core/serial_port_mode_control.sv ----
`timescale 1ns/10ps
`include "spmc_consts.svh"
module serial_port_mode_control
  import spmc_pkg::*;
(
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            srst,
  // Register port
  input  wire logic [7:0]      addr,
  input  wire logic [7:0]      wdata,
  input  wire logic            wr,
  input  wire logic            rd,
  output logic      [7:0]      rdata,
  // RS-232 transceiver side
  input  wire m232_in_t [1:0]  m232_i,
  output m232_out_t     [1:0]  m232_o,
  // RS-422/485 transceiver side
  input  wire logic     [1:0]  r485_rx_i,
  output r485_out_t     [1:0]  r485_o
);
  localparam logic [15:0] MIN_DIV = 16'(`SPMC_MIN_DIV);

  // Mode-select output port and its direction
  logic [3:0]       gpio_out_q, gpio_dir_q;
  logic [7:0]       rdata_q, rd_d;
  logic [3:0]       mode_stat;
  port_mode_t       mode_q [2];
  port_mode_t       mode_d [2];
  logic [1:0]       half_q, half_d;
  logic [1:0]       is485;
  logic [15:0]      div_q [2];
  logic [15:0]      div_d [2];
  logic [1:0]       mcr_q [2];
  m232_out_t [1:0]  m232_q, m232_d;
  r485_out_t [1:0]  r485_q, r485_d;
  logic [7:0]       rd_port [2];
  logic [1:0]       hit, rx_src, thr_empty, tx_busy, txd, rx_ready, rx_over;
  logic [7:0]       rx_byte [2];
  logic [3:0]       sub;
  logic             wr_gout, wr_gdir;

  // Global decode
  assign sub     = addr[3:0];
  assign wr_gout = wr && addr == `SPMC_A_GPIO_OUT;
  assign wr_gdir = wr && addr == `SPMC_A_GPIO_DIR;

  // Mode-select port registers; levels act only once lines are outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      gpio_out_q <= `SPMC_GPIO_RST;
      gpio_dir_q <= `SPMC_GPIO_RST;
    end else begin
      if (wr_gout) gpio_out_q <= wdata[3:0];
      if (wr_gdir) gpio_dir_q <= wdata[3:0];
    end
  end

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_port
      localparam int ML = `SPMC_LINES_PER_PORT * i;
      localparam int DL = ML + 1;
      logic        wr_data, wr_divl, wr_divh, wr_mcr;
      logic        rd_data, rd_lsr;
      logic [15:0] div_new;
      logic [7:0]  lsr, msr;

      // Mode follows its own line only while that line is an output;
      // an input line freezes the last mode rather than guessing one
      assign mode_d[i] = !gpio_dir_q[ML] ? mode_q[i] :
                         gpio_out_q[ML] ? MODE_RS232 :
                         MODE_RS485;
      assign half_d[i] = gpio_dir_q[DL] ? gpio_out_q[DL] : half_q[i];
      assign is485[i]  = mode_q[i] == MODE_RS485;

      // Port register decode
      assign hit[i]  = addr[7:4] == `SPMC_PSEL0 + 4'(i);
      assign wr_data = wr && hit[i] && sub == `SPMC_R_DATA;
      assign wr_divl = wr && hit[i] && sub == `SPMC_R_DIVL;
      assign wr_divh = wr && hit[i] && sub == `SPMC_R_DIVH;
      assign wr_mcr  = wr && hit[i] && sub == `SPMC_R_MCR;
      assign rd_data = rd && hit[i] && sub == `SPMC_R_DATA;
      assign rd_lsr  = rd && hit[i] && sub == `SPMC_R_LSR;

      // Divisor clamped so the port never runs above its top rate
      assign div_new  = wr_divl ? {div_q[i][15:8], wdata} :
                        wr_divh ? {wdata, div_q[i][7:0]} : div_q[i];
      assign div_d[i] = (div_new < MIN_DIV) ? MIN_DIV : div_new;

      // In RS-422/485 the receive pair feeds the UART even while sending,
      // so a joined half-duplex pair returns our own echo
      assign rx_src[i] = is485[i] ? r485_rx_i[i] : m232_i[i].rxd;

      // 16550-style status layouts
      assign lsr = {1'b0, thr_empty[i] & ~tx_busy[i], thr_empty[i],
                    3'h0, rx_over[i], rx_ready[i]};
      assign msr = is485[i] ? 8'h00 : {m232_i[i].dcd, m232_i[i].ri,
                    m232_i[i].dsr, m232_i[i].cts, 4'h0};
      assign rd_port[i] = sub == `SPMC_R_DATA ? rx_byte[i] :
                          sub == `SPMC_R_LSR  ? lsr :
                          sub == `SPMC_R_DIVL ? div_q[i][7:0] :
                          sub == `SPMC_R_DIVH ? div_q[i][15:8] :
                          sub == `SPMC_R_MCR  ? {6'h00, mcr_q[i]} :
                          sub == `SPMC_R_MSR  ? msr : 8'h00;

      // Pin drive: idle lines sit at mark, the unused transceiver is off
      assign m232_d[i].txd    = is485[i] | txd[i];
      assign m232_d[i].rts    = ~is485[i] & mcr_q[i][`SPMC_MCR_RTS];
      assign m232_d[i].dtr    = ~is485[i] & mcr_q[i][`SPMC_MCR_DTR];
      assign m232_d[i].drv_en = ~is485[i];
      assign r485_d[i].tx     = ~is485[i] | txd[i];
      assign r485_d[i].de     = is485[i] & tx_busy[i];
      assign r485_d[i].rx_en  = is485[i];
      assign r485_d[i].pair_join = is485[i] & half_q[i];

      // Per-port state; each port keeps its own settings
      always_ff @(posedge mclk) begin
        if (srst) begin
          mode_q[i] <= MODE_RS232;
          half_q[i] <= 1'b0;
          div_q[i]  <= MIN_DIV;
          mcr_q[i]  <= `SPMC_MCR_RST;
        end else begin
          mode_q[i] <= mode_d[i];
          half_q[i] <= half_d[i];
          div_q[i]  <= div_d[i];
          if (wr_mcr) mcr_q[i] <= wdata[1:0];
        end
      end

      uart_engine u_uart (
        .mclk      (mclk),
        .srst      (srst),
        .div       (div_q[i]),
        .tx_byte   (wdata),
        .tx_load   (wr_data),
        .thr_empty (thr_empty[i]),
        .tx_busy   (tx_busy[i]),
        .txd       (txd[i]),
        .rxd       (rx_src[i]),
        .rbr_clr   (rd_data),
        .oe_clr    (rd_lsr),
        .rx_byte   (rx_byte[i]),
        .rx_ready  (rx_ready[i]),
        .rx_over   (rx_over[i])
      );

      // Checks on mode selection and transceiver control
      a_mode_rs232: assert property (@(posedge mclk) disable iff (srst)
        (gpio_dir_q[ML] && gpio_out_q[ML]) |=> mode_q[i] == MODE_RS232)
        else $error("mode line high did not give RS-232");
      a_mode_rs485: assert property (@(posedge mclk) disable iff (srst)
        (gpio_dir_q[ML] && !gpio_out_q[ML]) |=> mode_q[i] == MODE_RS485)
        else $error("mode line low did not give RS-422/485");
      a_duplex_sel: assert property (@(posedge mclk) disable iff (srst)
        gpio_dir_q[DL] |=> half_q[i] == $past(gpio_out_q[DL]))
        else $error("duplex line not followed");
      a_port_isolate: assert property (@(posedge mclk) disable iff (srst)
        !gpio_dir_q[ML] |=> $stable(mode_q[i]))
        else $error("mode changed without its own line");
      a_auto_de: assert property (@(posedge mclk) disable iff (srst)
        (is485[i] && tx_busy[i]) |=> r485_q[i].de ##0 r485_q[i].rx_en)
        else $error("driver enable missing during frame");
      a_de_release: assert property (@(posedge mclk) disable iff (srst)
        $fell(tx_busy[i]) |=> !r485_q[i].de)
        else $error("driver enable held after last stop bit");
      a_pair_join: assert property (@(posedge mclk) disable iff (srst)
        1'b1 |=> r485_q[i].pair_join == $past(is485[i] && half_q[i]))
        else $error("pair join wrong for mode");
      a_full_modem: assert property (@(posedge mclk) disable iff (srst)
        !is485[i] |=> m232_q[i].drv_en &&
        m232_q[i].rts == $past(mcr_q[i][`SPMC_MCR_RTS]))
        else $error("RS-232 modem lines not driven");
      a_echo_rx: assert property (@(posedge mclk) disable iff (srst)
        is485[i] |-> rx_src[i] == r485_rx_i[i])
        else $error("receiver not on the RS-485 pair");
      a_div_limit: assert property (@(posedge mclk) disable iff (srst)
        div_q[i] >= MIN_DIV)
        else $error("divisor above top rate");

      c_to_rs485: cover property (@(posedge mclk) disable iff (srst)
        $fell(m232_q[i].drv_en));
      c_half_frame: cover property (@(posedge mclk) disable iff (srst)
        r485_q[i].pair_join && r485_q[i].de);
      c_back_232: cover property (@(posedge mclk) disable iff (srst)
        $rose(m232_q[i].drv_en));
      c_rx_char: cover property (@(posedge mclk) disable iff (srst)
        $rose(rx_ready[i]) && is485[i]);
    end
  endgenerate

  // Effective mode per port for software
  assign mode_stat = {half_q[1], is485[1], half_q[0], is485[0]};

  // Read selection; unmapped addresses read zero
  assign rd_d = addr == `SPMC_A_GPIO_OUT  ? {4'h0, gpio_out_q} :
                addr == `SPMC_A_GPIO_DIR  ? {4'h0, gpio_dir_q} :
                addr == `SPMC_A_MODE_STAT ? {4'h0, mode_stat} :
                hit[0] ? rd_port[0] :
                hit[1] ? rd_port[1] : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (srst) rdata_q <= 8'h00;
    else rdata_q <= rd ? rd_d : 8'h00;
  end

  // Registered pin outputs; reset shows RS-232 idle
  always_ff @(posedge mclk) begin
    if (srst) begin
      m232_q <= {2{4'b1001}};
      r485_q <= {2{4'b1000}};
    end else begin
      m232_q <= m232_d;
      r485_q <= r485_d;
    end
  end

  // Reset must leave both ports in RS-232
  a_reset_rs232: assert property (@(posedge mclk)
    $past(srst) |-> mode_q[0] == MODE_RS232 && mode_q[1] == MODE_RS232)
    else $error("port not RS-232 after reset");

  assign rdata  = rdata_q;
  assign m232_o = m232_q;
  assign r485_o = r485_q;
endmodule

// ---- dv/remote_node.sv ----
`timescale 1ns/10ps
module remote_node
  import spmc_pkg::*;
(
  // Line side of the block under test
  input  wire m232_out_t [1:0] m232_o,
  input  wire r485_out_t [1:0] r485_o,
  // Modem status raised by the remote, per port {cts,dsr,dcd,ri}
  input  wire logic      [7:0] modem,
  // Lines back into the block
  output m232_in_t       [1:0] m232_i,
  output logic           [1:0] r485_rx_i
);
  // Remote loops our data back; an undriven line rests at mark, as the bias sets it
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      m232_i[p].rxd = m232_o[p].drv_en ? m232_o[p].txd : 1'b1;
      {m232_i[p].cts, m232_i[p].dsr, m232_i[p].dcd, m232_i[p].ri} = modem[4*p +: 4];
      // Our own frame comes back to the receiver whenever the driver is on, joined or not
      r485_rx_i[p] = r485_o[p].de ? r485_o[p].tx : 1'b1;
    end
  end
endmodule

// ---- dv/test_serial_port_mode_control.sv ----
`timescale 1ns/10ps
module test_serial_port_mode_control
  import spmc_pkg::*;
;
  logic             mclk;
  logic             srst;
  logic [7:0]       addr;
  logic [7:0]       wdata;
  logic             wr;
  logic             rd;
  logic [7:0]       rdata;
  logic [7:0]       modem;
  m232_in_t  [1:0]  m232_i;
  m232_out_t [1:0]  m232_o;
  logic      [1:0]  r485_rx_i;
  r485_out_t [1:0]  r485_o;
  int               errors;
  int               total_checks;
  int               cnt;
  int               falls;
  logic             prev;

  serial_port_mode_control i_dut (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .m232_i(m232_i), .m232_o(m232_o), .r485_rx_i(r485_rx_i),
    .r485_o(r485_o));

  remote_node i_far (
    .m232_o(m232_o), .r485_o(r485_o), .modem(modem), .m232_i(m232_i),
    .r485_rx_i(r485_rx_i));

  // 20 MHz clock
  always #25 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One-cycle write strobe, then one idle cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(a, v);
    check(v, exp);
  endtask

  // Mode lines reach the pins three cycles after the write
  task automatic set_out(input logic [3:0] v);
    reg_wr(8'h00, {4'h0, v});
    repeat (4) @(posedge mclk);
    #1;
  endtask

  // Status {half1,is485_1,half0,is485_0} from the line levels
  function automatic logic [7:0] stat_exp(input logic [3:0] v);
    return {4'h0, v[3], ~v[2], v[1], ~v[0]};
  endfunction

  // Watchdog sized well past the four serial frames and the mode sweep
  initial begin
    repeat (30000) @(posedge mclk);
    errors++;
    report_and_stop();
  end

  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    modem = 8'h00;
    errors = 0;
    total_checks = 0;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1;
    // Out of reset both ports are RS-232 with the driver on
    check({7'h0, m232_o[0].drv_en & m232_o[1].drv_en}, 8'h01);
    check({6'h0, r485_o[0].de, r485_o[1].de}, 8'h00);
    rd_chk(8'h02, 8'h00);
    // Levels on lines still set as inputs change nothing
    set_out(4'h0);
    rd_chk(8'h02, 8'h00);
    // Every line combination once all four lines are outputs
    reg_wr(8'h01, 8'h0f);
    for (int v = 0; v < 16; v++) begin
      set_out(v[3:0]);
      rd_chk(8'h02, stat_exp(v[3:0]));
      check({7'h0, r485_o[0].pair_join}, {7'h0, ~v[0] & v[1]});
      check({7'h0, r485_o[1].pair_join}, {7'h0, ~v[2] & v[3]});
    end
    // Only the first port's lines as outputs: second port holds its mode
    reg_wr(8'h01, 8'h03);
    set_out(4'h0);
    rd_chk(8'h02, 8'h09);
    // First port RS-485 half duplex, second RS-232 full duplex
    reg_wr(8'h01, 8'h0f);
    set_out(4'h6);
    check({4'h0, r485_o[0].rx_en, m232_o[0].drv_en, r485_o[1].rx_en, m232_o[1].drv_en},
          8'h09);
    // Divisor resets to the fastest legal rate and refuses anything faster
    rd_chk(8'h12, 8'hae);
    rd_chk(8'h13, 8'h00);
    reg_wr(8'h12, 8'h01);
    rd_chk(8'h12, 8'hae);
    // Two bytes queued: the driver stays on across both frames with no gap
    reg_wr(8'h10, 8'h3c);
    reg_wr(8'h10, 8'hc3);
    cnt = 0;
    falls = 0;
    prev = 1'b0;
    // Sampling starts in the cycle where the driver enable first shows,
    // so all 2 x 10 bit periods of 174 cycles are counted
    for (int i = 0; i < 4000; i++) begin
      #1;
      if (r485_o[0].de) cnt++;
      if (prev && !r485_o[0].de) falls++;
      prev = r485_o[0].de;
      @(posedge mclk);
    end
    check({7'h0, cnt >= 3480 && cnt <= 3482}, 8'h01);
    check(falls[7:0], 8'h01);
    // Both echoes came back; the second overran the first
    rd_chk(8'h11, 8'h63);
    rd_chk(8'h10, 8'hc3);
    rd_chk(8'h11, 8'h60);
    // A single byte echoes back whole
    reg_wr(8'h10, 8'ha5);
    repeat (2000) @(posedge mclk);
    rd_chk(8'h11, 8'h61);
    rd_chk(8'h10, 8'ha5);
    // RS-232 port loops its own frame back; the other port hears nothing
    reg_wr(8'h20, 8'h5a);
    repeat (2000) @(posedge mclk);
    rd_chk(8'h21, 8'h61);
    rd_chk(8'h20, 8'h5a);
    rd_chk(8'h11, 8'h60);
    // Modem control and status on the RS-232 port only
    reg_wr(8'h24, 8'h03);
    reg_wr(8'h14, 8'h03);
    modem <= 8'ha9;
    repeat (4) @(posedge mclk);
    #1;
    check({6'h0, m232_o[1].rts, m232_o[1].dtr}, 8'h03);
    check({6'h0, m232_o[0].rts, m232_o[0].dtr}, 8'h00);
    check({5'h0, r485_o[1].tx, m232_o[1].txd, m232_o[0].txd}, 8'h07);
    rd_chk(8'h25, 8'h90);
    rd_chk(8'h15, 8'h00);
    // Unmapped place reads as zero
    rd_chk(8'h7f, 8'h00);
    report_and_stop();
  end
endmodule
